// ===== logic/tw_slave.sv
`timescale 1ns/1ns
module tw_slave #(
   parameter int PROG_CYCLES = tw_slave_pkg::TRIP_PROG_CYC
) (
   input  wire logic        clk_sys,
   input  wire logic        nrst,
   input  wire logic        sclIn,
   input  wire logic        sdaIn,
   output logic             sdaOut,
   output logic             sdaOe,
   input  wire logic        writeEnableLatch,
   input  wire logic        protectSelectBit0,
   input  wire logic        protectSelectBit1,
   input  wire logic        protectSelectBit2,
   input  wire logic        resetPinAtVp,
   input  wire logic        nvBusy,
   input  wire logic [7:0]  rdData,
   output logic [15:0]      wordAddr,
   output logic             regSpace,
   output logic [7:0]       wrData,
   output logic             wrStrobe,
   output logic             standby,
   output logic             tripProgSet,
   output logic             tripProgClr,
   output logic             tripBusy
);
   import tw_slave_pkg::*;

   state_s s_ff;
   state_s nxt_s;
   logic [31:0] progCnt_ff;
   logic [31:0] nxt_progCnt;

   ////////////////////////////////////////////////////////////////////////
   function automatic logic addr_match(input logic [7:0] b);
      return (b[7:4] == ID_ARRAY || b[7:4] == ID_REGSPACE) && b[3:1] == DEV_SELECT; // R7 R8 R10
   endfunction

   logic scl;
   logic sda;
   logic sclRise;
   logic sclFall;
   logic startSeen;
   logic stopSeen;
   logic busy;
   // helpers for the checks below: no bus condition, and the eighth bit just ended
   logic quiet;
   logic byteEnd;
   always_comb
   begin
      scl       = s_ff.sclSync[1];
      sda       = s_ff.sdaSync[1];
      sclRise   = scl & ~s_ff.sclD;
      sclFall   = ~scl & s_ff.sclD;
      startSeen = scl & s_ff.sclD & s_ff.sdaD & ~sda; // R1 R2
      stopSeen  = scl & s_ff.sclD & ~s_ff.sdaD & sda; // R2
      busy      = nvBusy | (progCnt_ff != 32'h0);
      quiet     = ~startSeen & ~stopSeen;
      byteEnd   = sclFall & (s_ff.bitCnt == 4'h8) & quiet;
   end

   ////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      nxt_s          = s_ff;
      nxt_progCnt    = (progCnt_ff != 32'h0) ? progCnt_ff - 32'h1 : progCnt_ff;
      nxt_s.sclSync  = {s_ff.sclSync[0], sclIn};
      nxt_s.sdaSync  = {s_ff.sdaSync[0], sdaIn};
      nxt_s.sclD     = scl;
      nxt_s.sdaD     = sda;
      nxt_s.wrStrobe = 1'b0;
      nxt_s.progSet  = 1'b0;
      nxt_s.progClr  = 1'b0;
      if (startSeen)
      begin
         // restart lands in the address phase, or in idle while busy
         nxt_s.phase    = busy ? IDLE : SLAVE; // R1 R23 R24
         nxt_s.bitCnt   = 4'h0;
         nxt_s.ackDrive = 1'b0;
         nxt_s.sdaOut   = 1'b1;
         nxt_s.wroteOk  = 1'b0;
      end
      else if (stopSeen)
      begin
         // trip programming only after a full acked data byte
         if (s_ff.wroteOk && resetPinAtVp && !(protectSelectBit0 | protectSelectBit1
             | protectSelectBit2)) // R22
         begin
            nxt_s.progSet = s_ff.tripSet; // R19
            nxt_s.progClr = s_ff.tripClr; // R20
            if (s_ff.tripSet | s_ff.tripClr)
               nxt_progCnt = 32'(PROG_CYCLES);
         end
         nxt_s.phase    = IDLE; // R4
         nxt_s.ackDrive = 1'b0;
         nxt_s.sdaOut   = 1'b1;
         nxt_s.wroteOk  = 1'b0;
      end
      else if (s_ff.phase != IDLE)
      begin
         unique case (s_ff.phase)
            SLAVE, WADDR, WDATA:
               if (sclRise)
               begin
                  nxt_s.shift  = {s_ff.shift[6:0], sda};
                  nxt_s.bitCnt = s_ff.bitCnt + 4'h1;
               end
               else if (sclFall && s_ff.bitCnt == 4'h8) // R6
               begin
                  nxt_s.bitCnt = 4'h0;
                  nxt_s.phase  = ACK;
                  nxt_s.ackDrive = 1'b1;
                  if (s_ff.phase == SLAVE)
                  begin
                     nxt_s.ackDrive     = addr_match(s_ff.shift); // R10
                     nxt_s.tgt.regSpace = s_ff.shift[7:4] == ID_REGSPACE; // R7
                     nxt_s.tgt.read     = s_ff.shift[0]; // R9
                     nxt_s.wByte        = 2'h0;
                     nxt_s.dataCnt      = 2'h0;
                     nxt_s.afterAck     = !addr_match(s_ff.shift) ? IDLE
                                        : s_ff.shift[0] ? RDATA : WADDR;
                  end
                  else if (s_ff.phase == WADDR)
                  begin
                     // high byte first
                     nxt_s.wordAddr = s_ff.wByte == 2'h0 ? {s_ff.shift, s_ff.wordAddr[7:0]}
                                                        : {s_ff.wordAddr[15:8], s_ff.shift}; // R11
                     nxt_s.wByte    = s_ff.wByte + 2'h1;
                     nxt_s.afterAck = s_ff.wByte == 2'h0 ? WADDR : WDATA;
                  end
                  else
                  begin
                     nxt_s.ackDrive = writeEnableLatch // R14 R15
                        && !(s_ff.tgt.regSpace && s_ff.wordAddr == STATUS_ADDR
                             && s_ff.dataCnt != 2'h0); // R16
                     nxt_s.afterAck = WDATA;
                     if (nxt_s.ackDrive)
                     begin
                        nxt_s.wrData   = s_ff.shift;
                        nxt_s.wrStrobe = 1'b1;
                        nxt_s.wroteOk  = 1'b1;
                        nxt_s.dataCnt  = (s_ff.dataCnt == 2'h3) ? 2'h3 : s_ff.dataCnt + 2'h1;
                        nxt_s.tripSet  = !s_ff.tgt.regSpace && s_ff.wordAddr == TRIP_SET_ADDR
                                         && s_ff.shift == TRIP_DATA;
                        nxt_s.tripClr  = !s_ff.tgt.regSpace && s_ff.wordAddr == TRIP_CLR_ADDR
                                         && s_ff.shift == TRIP_DATA;
                     end
                  end
                  nxt_s.sdaOut = ~nxt_s.ackDrive;
               end
            ACK:
               if (sclFall)
               begin
                  nxt_s.ackDrive = 1'b0; // R6
                  nxt_s.sdaOut   = 1'b1;
                  nxt_s.phase    = s_ff.afterAck;
                  if (s_ff.afterAck == RDATA)
                  begin
                     nxt_s.shift    = rdData;
                     nxt_s.ackDrive = ~rdData[7];
                     nxt_s.sdaOut   = rdData[7];
                  end
               end
            RDATA:
               if (sclFall)
               begin
                  nxt_s.bitCnt = s_ff.bitCnt + 4'h1;
                  if (s_ff.bitCnt == 4'h7) // R17
                  begin
                     nxt_s.ackDrive = 1'b0;
                     nxt_s.sdaOut   = 1'b1;
                     nxt_s.phase    = RACK;
                     nxt_s.wordAddr = s_ff.wordAddr + 16'h1;
                  end
                  else
                  begin
                     nxt_s.shift    = {s_ff.shift[6:0], 1'b0};
                     nxt_s.ackDrive = ~s_ff.shift[6]; // R2
                     nxt_s.sdaOut   = s_ff.shift[6];
                  end
               end
            RACK:
               if (sclRise)
                  nxt_s.wasRead = sda; // nack latched here
               else if (sclFall)
               begin
                  nxt_s.bitCnt = 4'h0;
                  nxt_s.phase  = s_ff.wasRead ? IDLE : RDATA; // R17
                  if (!s_ff.wasRead)
                  begin
                     nxt_s.shift    = rdData;
                     nxt_s.ackDrive = ~rdData[7];
                     nxt_s.sdaOut   = rdData[7];
                  end
               end
            default:
               nxt_s.phase = IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         s_ff          <= '0;
         s_ff.sclSync  <= 2'h3;
         s_ff.sdaSync  <= 2'h3;
         s_ff.sclD     <= 1'b1;
         s_ff.sdaD     <= 1'b1;
         s_ff.sdaOut   <= 1'b1;
         s_ff.phase    <= IDLE;
         s_ff.afterAck <= IDLE;
         s_ff.wordAddr <= WADDR_RESET; // R12
         progCnt_ff    <= 32'h0;
      end
      else
      begin
         s_ff       <= nxt_s;
         progCnt_ff <= nxt_progCnt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // open drain: only ever pull low; scl is never driven
   assign sdaOut      = 1'b0; // R3
   assign sdaOe       = s_ff.ackDrive;
   assign wordAddr    = s_ff.wordAddr;
   assign regSpace    = s_ff.tgt.regSpace;
   assign wrData      = s_ff.wrData;
   assign wrStrobe    = s_ff.wrStrobe;
   assign standby     = s_ff.phase == IDLE;
   assign tripProgSet = s_ff.progSet;
   assign tripProgClr = s_ff.progClr;
   assign tripBusy    = progCnt_ff != 32'h0;

   ////////////////////////////////////////////////////////////////////////
   chk_stop_idle: assert property (@(posedge clk_sys) disable iff (!nrst)
      stopSeen |=> standby) else $error("stop did not return to standby"); // R4
   chk_nomatch_silent: assert property (@(posedge clk_sys) disable iff (!nrst)
      (s_ff.phase == SLAVE && sclFall && s_ff.bitCnt == 4'h8 && !startSeen && !stopSeen
       && !addr_match(s_ff.shift)) |=> !sdaOe) else $error("ack on bad address"); // R10
   chk_match_ack: assert property (@(posedge clk_sys) disable iff (!nrst)
      (s_ff.phase == SLAVE && sclFall && s_ff.bitCnt == 4'h8 && !startSeen && !stopSeen
       && addr_match(s_ff.shift)) |=> sdaOe) else $error("no ack on match"); // R10
   chk_wel_block: assert property (@(posedge clk_sys) disable iff (!nrst)
      wrStrobe |-> $past(writeEnableLatch))
      else $error("write taken without latch"); // R15
   chk_busy_quiet: assert property (@(posedge clk_sys) disable iff (!nrst)
      (tripBusy && s_ff.phase == IDLE) |-> !sdaOe) else $error("driven while busy"); // R23
   chk_start_restart: assert property (@(posedge clk_sys) disable iff (!nrst)
      (startSeen && !busy) |=> s_ff.phase == SLAVE && !sdaOe) else $error("no restart"); // R24
   chk_sda_scl_low: assert property (@(posedge clk_sys) disable iff (!nrst)
      $changed(sdaOe) |-> !s_ff.sclD || $past(startSeen) || $past(stopSeen))
      else $error("sda moved with scl high"); // R2
   chk_trip_pulse: assert property (@(posedge clk_sys) disable iff (!nrst)
      tripProgSet |-> tripBusy && !tripProgClr) else $error("trip pulse wrong"); // R19
   chk_rack_release: assert property (@(posedge clk_sys) disable iff (!nrst)
      s_ff.phase == RACK |-> !sdaOe) else $error("sda held in read ack"); // R6 R17

   ////////////////////////////////////////////////////////////////////////
   // line level: the pin is open drain, nothing drives while idle
   chk_drive_low: assert property (@(posedge clk_sys) disable iff (!nrst)
      sdaOut == 1'b0) else $error("sda driven high"); // R3
   chk_idle_silent: assert property (@(posedge clk_sys) disable iff (!nrst)
      s_ff.phase == IDLE |-> !sdaOe) else $error("sda driven while idle"); // R1
   chk_stop_release: assert property (@(posedge clk_sys) disable iff (!nrst)
      stopSeen |=> !sdaOe) else $error("sda held after stop"); // R4
   chk_bit_capture: assert property (@(posedge clk_sys) disable iff (!nrst)
      (s_ff.phase == SLAVE && sclRise && quiet) |=> s_ff.shift[0] == $past(sda))
      else $error("bit not taken on scl rise"); // R2

   ////////////////////////////////////////////////////////////////////////
   // acknowledge slot: held through the ninth clock, dropped at its end unless a read byte follows; read bits held likewise
   chk_ack_hold: assert property (@(posedge clk_sys) disable iff (!nrst)
      (s_ff.phase == ACK && !sclFall && quiet) |=> $stable(sdaOe))
      else $error("ack moved inside ninth clock"); // R6
   chk_ack_drop: assert property (@(posedge clk_sys) disable iff (!nrst)
      (s_ff.phase == ACK && sclFall && quiet && s_ff.afterAck != RDATA) |=> !sdaOe)
      else $error("ack not released"); // R6
   chk_rbit_hold: assert property (@(posedge clk_sys) disable iff (!nrst)
      (s_ff.phase == RDATA && !sclFall && quiet) |=> $stable(sdaOe))
      else $error("read bit moved while scl high"); // R2

   ////////////////////////////////////////////////////////////////////////
   // slave byte decode
   chk_read_dir: assert property (@(posedge clk_sys) disable iff (!nrst)
      (s_ff.phase == SLAVE && byteEnd && addr_match(s_ff.shift) && s_ff.shift[0])
      |=> s_ff.afterAck == RDATA) else $error("read not selected"); // R9
   chk_write_dir: assert property (@(posedge clk_sys) disable iff (!nrst)
      (s_ff.phase == SLAVE && byteEnd && addr_match(s_ff.shift) && !s_ff.shift[0])
      |=> s_ff.afterAck == WADDR) else $error("write not selected"); // R9 R11
   chk_space_sel: assert property (@(posedge clk_sys) disable iff (!nrst)
      (s_ff.phase == SLAVE && byteEnd && addr_match(s_ff.shift))
      |=> regSpace == ($past(s_ff.shift[7:4]) == ID_REGSPACE))
      else $error("target space wrong"); // R7

   ////////////////////////////////////////////////////////////////////////
   // word address: two bytes, high first, both acknowledged
   chk_waddr_high: assert property (@(posedge clk_sys) disable iff (!nrst)
      (s_ff.phase == WADDR && byteEnd && s_ff.wByte == 2'h0)
      |=> wordAddr[15:8] == $past(s_ff.shift)) else $error("high address byte"); // R11
   chk_waddr_low: assert property (@(posedge clk_sys) disable iff (!nrst)
      (s_ff.phase == WADDR && byteEnd && s_ff.wByte == 2'h1)
      |=> wordAddr[7:0] == $past(s_ff.shift)) else $error("low address byte"); // R11
   chk_waddr_ack: assert property (@(posedge clk_sys) disable iff (!nrst)
      (s_ff.phase == WADDR && byteEnd) |=> sdaOe) else $error("address unacked"); // R11 R14

   ////////////////////////////////////////////////////////////////////////
   // data bytes of a write
   chk_data_ack: assert property (@(posedge clk_sys) disable iff (!nrst)
      (s_ff.phase == WDATA && byteEnd && writeEnableLatch && !s_ff.tgt.regSpace)
      |=> sdaOe && wrStrobe) else $error("data byte unacked"); // R14
   chk_wel_noack: assert property (@(posedge clk_sys) disable iff (!nrst)
      (s_ff.phase == WDATA && byteEnd && !writeEnableLatch) |=> !sdaOe)
      else $error("data acked without latch"); // R15
   chk_status_once: assert property (@(posedge clk_sys) disable iff (!nrst)
      (s_ff.phase == WDATA && byteEnd && s_ff.tgt.regSpace
       && s_ff.wordAddr == STATUS_ADDR && s_ff.dataCnt != 2'h0) |=> !sdaOe)
      else $error("second status byte acked"); // R16

   ////////////////////////////////////////////////////////////////////////
   // read bytes: counter steps per byte, master ack decides what follows
   chk_read_inc: assert property (@(posedge clk_sys) disable iff (!nrst)
      (s_ff.phase == RDATA && sclFall && s_ff.bitCnt == 4'h7 && quiet)
      |=> wordAddr == $past(wordAddr) + 16'h1) else $error("read address stuck"); // R17
   chk_nack_end: assert property (@(posedge clk_sys) disable iff (!nrst)
      (s_ff.phase == RACK && sclFall && s_ff.wasRead && quiet) |=> standby)
      else $error("read went on after nack"); // R17
   chk_ack_more: assert property (@(posedge clk_sys) disable iff (!nrst)
      (s_ff.phase == RACK && sclFall && !s_ff.wasRead && quiet) |=> s_ff.phase == RDATA)
      else $error("read stopped after ack"); // R17

   ////////////////////////////////////////////////////////////////////////
   // busy and threshold programming; a limitation: only array address 01h/03h count
   chk_busy_ignore: assert property (@(posedge clk_sys) disable iff (!nrst)
      (startSeen && busy) |=> standby && !sdaOe) else $error("start taken while busy"); // R23
   chk_trip_guard: assert property (@(posedge clk_sys) disable iff (!nrst)
      (tripProgSet || tripProgClr) |-> $past(resetPinAtVp)
      && $past(!(protectSelectBit0 | protectSelectBit1 | protectSelectBit2)))
      else $error("trip programmed unguarded"); // R19 R20 R22
   chk_clr_pulse: assert property (@(posedge clk_sys) disable iff (!nrst)
      tripProgClr |-> tripBusy && !tripProgSet) else $error("clear pulse wrong"); // R20
endmodule // tw_slave

// ===== shared/tw_slave_pkg.sv
// How it works
// [R1] watch lines always; ignore until start
// [R2] sda moves only while scl low
// [R3] master clocks; device never drives scl
// [R4] stop after read returns to standby
// [R5] master stops only after sda released
// [R6] release after eight bits; ack ninth
// [R7] upper nibble 1010 array, 1101 registers
// [R8] select bits three..one must be 111
// [R9] bit zero one read, zero write
// [R10] ack address only on full match
// [R11] two word address bytes, high first, acked
// [R12] power-up clears word address counter
// [R13] random read repeats same slave byte
// [R14] selected write acks every later byte
// [R15] no data ack while write_enable_latch low
// [R16] status write: second data byte unacked
// [R17] read: eight bits, ack continues, else end
// [R18] master stops after read nack
// [R19] reset pin at vp, 00h to 01h sets trip
// [R20] reset pin at vp, 00h to 03h clears trip
// [R21] master clears before setting threshold
// [R22] protect bits must be clear to program
// [R23] busy in write cycle: no ack, released
// [R24] start mid transfer restarts address phase
package tw_slave_pkg;
   localparam logic [3:0]  ID_ARRAY      = 4'ha;
   localparam logic [3:0]  ID_REGSPACE   = 4'hd;
   localparam logic [2:0]  DEV_SELECT    = 3'h7;
   localparam logic [15:0] WADDR_RESET   = 16'h0000;
   localparam logic [15:0] STATUS_ADDR   = 16'h003f;
   localparam logic [15:0] TRIP_SET_ADDR = 16'h0001;
   localparam logic [15:0] TRIP_CLR_ADDR = 16'h0003;
   localparam logic [7:0]  TRIP_DATA     = 8'h00;
   localparam int          TRIP_PROG_MS  = 10;
   localparam int          CLK_MHZ       = 100;
   localparam int          TRIP_PROG_CYC = TRIP_PROG_MS * 1000 * CLK_MHZ;

   typedef enum logic [2:0] {IDLE, SLAVE, WADDR, WDATA, RDATA, ACK, RACK} phase_e;

   typedef struct packed {
      logic       data;
      logic       regSpace;
      logic       read;
   } target_s;

   typedef struct packed {
      logic [1:0] sclSync;
      logic [1:0] sdaSync;
      logic       sclD;
      logic       sdaD;
      phase_e     phase;
      phase_e     afterAck;
      logic [3:0] bitCnt;
      logic [7:0] shift;
      logic [1:0] wByte;
      logic [1:0] dataCnt;
      logic [15:0] wordAddr;
      target_s    tgt;
      logic       ackDrive;
      logic       sdaOut;
      logic       wasRead;
      logic       wroteOk;
      logic       tripSet;
      logic       tripClr;
      logic [7:0] wrData;
      logic       wrStrobe;
      logic       progSet;
      logic       progClr;
   } state_s;
endpackage

// ===== sim/tb_tw_slave.sv
`timescale 1ns/1ns
module tb_tw_slave;
   import tw_slave_pkg::*;
   localparam int PROG = 400;
   logic        clk_sys = 1'b0;
   logic        nrst = 1'b0;
   logic        write_enable_latch = 1'b1, vp = 1'b0, busy = 1'b0;
   logic [2:0]  prot = 3'h0;
   logic [7:0]  rdData = 8'h00, wrData, lastWr, sb, r, d1, d2;
   logic [7:0]  corner [4] = '{8'hae, 8'hde, 8'hac, 8'h9e};
   logic [15:0] wordAddr, a;
   logic [4:0]  acks;
   logic        scl, sdaM, sdaOut, sdaOe, sdaLine, ack, exp;
   logic        regSpace, wrStrobe, standby, tripProgSet, tripProgClr, tripBusy;
   int          seed = 45670, err_total = 0, checked = 0, setCnt = 0, clrCnt = 0, s0, c0;
   always #5 clk_sys = ~clk_sys;
   // slave only ever sinks the line; pull-up otherwise
   assign sdaLine = sdaM & ~(sdaOe & ~sdaOut);
   always @(posedge clk_sys)
   begin
      if (wrStrobe) lastWr <= wrData;
      if (tripProgSet) setCnt <= setCnt + 1;
      if (tripProgClr) clrCnt <= clrCnt + 1;
   end
   tw_slave #(.PROG_CYCLES(PROG)) i_tw_slave (.clk_sys(clk_sys), .nrst(nrst), .sclIn(scl),
      .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe), .writeEnableLatch(write_enable_latch),
      .protectSelectBit0(prot[0]), .protectSelectBit1(prot[1]), .protectSelectBit2(prot[2]),
      .resetPinAtVp(vp), .nvBusy(busy), .rdData(rdData), .wordAddr(wordAddr),
      .regSpace(regSpace), .wrData(wrData), .wrStrobe(wrStrobe), .standby(standby),
      .tripProgSet(tripProgSet), .tripProgClr(tripProgClr), .tripBusy(tripBusy));
   tw_master_model i_tw_master_model (.scl(scl), .sdaM(sdaM), .sdaLine(sdaLine));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [15:0] seen, input logic [15:0] expv);
      checked++;
      if (seen !== expv)
      begin
         err_total++;
         $display("ERROR t=%0t seen %h expected %h", $time, seen, expv);
      end
   endtask
   task automatic results;
      $display("checked %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic setIn(input logic w, input logic [2:0] p, input logic v, input logic b);
      @(posedge clk_sys);
      #1 write_enable_latch = w;
      prot = p;
      vp = v;
      busy = b;
   endtask
   task automatic frame(input logic [7:0] s, input logic [15:0] ad, input logic [7:0] d,
                        input int n);
      acks = 5'h00;
      i_tw_master_model.start;
      i_tw_master_model.wrByte(s, acks[0]);
      i_tw_master_model.wrByte(ad[15:8], acks[1]);
      i_tw_master_model.wrByte(ad[7:0], acks[2]);
      for (int i = 0; i < n; i++) i_tw_master_model.wrByte(d + 8'(i), acks[3+i]);
      i_tw_master_model.stop;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      #900000 err_total++;
      results;
   end
   initial
   begin
      repeat (8) @(posedge clk_sys);
      #1 nrst = 1'b1;
      repeat (3) @(posedge clk_sys);
      check(wordAddr, WADDR_RESET);
      check(standby, 1'b1);
      i_tw_master_model.wrByte(8'hae, ack);
      check(ack, 1'b0);
      i_tw_master_model.stop;
      $display("test idle done");
      for (int k = 0; k < 12; k++)
      begin
         sb = (k < 4) ? corner[k] : 8'($random(seed));
         sb[0] = 1'b0;
         a = 16'($random(seed));
         frame(sb, a, 8'h00, 0);
         exp = (sb[7:4] == ID_ARRAY || sb[7:4] == ID_REGSPACE) && sb[3:1] == DEV_SELECT;
         check(acks[0], exp);
         if (exp) check(acks[2:1], 2'h3);
         if (exp) check(regSpace, sb[7:4] == ID_REGSPACE);
         if (exp && sb[7:4] == ID_ARRAY) check(wordAddr, a);
      end
      $display("test decode done");
      frame(8'hae, 16'h0040, 8'h5a, 1);
      check(acks, 5'h0f);
      check(lastWr, 8'h5a);
      setIn(1'b0, 3'h0, 1'b0, 1'b0);
      frame(8'hae, 16'h0041, 8'h33, 1);
      check(acks, 5'h07);
      setIn(1'b1, 3'h0, 1'b0, 1'b0);
      frame(8'hde, STATUS_ADDR, 8'h02, 2);
      check(acks, 5'h0f);
      $display("test write done");
      r = 8'($random(seed));
      @(posedge clk_sys);
      #1 rdData = r;
      frame(8'hae, 16'h0123, 8'h00, 0);
      i_tw_master_model.start;
      i_tw_master_model.wrByte(8'haf, ack);
      check(ack, 1'b1);
      i_tw_master_model.rdByte(1'b1, d1);
      i_tw_master_model.rdByte(1'b0, d2);
      check({d1, d2}, {r, r});
      check(standby, 1'b0);
      i_tw_master_model.stop;
      repeat (3) @(posedge clk_sys);
      check(standby, 1'b1);
      check(wordAddr, 16'h0125);
      $display("test read done");
      setIn(1'b1, 3'h0, 1'b0, 1'b1);
      frame(8'hae, 16'h0000, 8'h00, 0);
      check(acks, 5'h00);
      // clear first, then set, then a set that protection must block
      for (int k = 0; k < 3; k++)
      begin
         setIn(1'b1, (k == 2) ? 3'h4 : 3'h0, 1'b1, 1'b0);
         s0 = setCnt;
         c0 = clrCnt;
         frame(8'hae, (k == 0) ? TRIP_CLR_ADDR : TRIP_SET_ADDR, TRIP_DATA, 1);
         i_tw_master_model.start;
         i_tw_master_model.wrByte(8'hae, ack);
         i_tw_master_model.stop;
         check(ack, k == 2);
         for (int i = 0; i < 1000 && tripBusy !== 1'b0; i++) @(posedge clk_sys);
         check(16'(clrCnt - c0), k == 0);
         check(16'(setCnt - s0), k == 1);
      end
      $display("test trip done");
      results;
   end
endmodule // tb_tw_slave

// ===== sim/tw_master_model.sv
`timescale 1ns/1ns
module tw_master_model (
   output logic      scl,
   output logic      sdaM,
   input  wire logic sdaLine
);
   // parked high between frames, data released to the pull-up
   initial
   begin
      scl  = 1'b1;
      sdaM = 1'b1;
   end
   task automatic bitx(input logic b, output logic s);
      #31 sdaM = b;
      #31 scl = 1'b1;
      #32 s = sdaLine;
      #31 scl = 1'b0;
   endtask
   task automatic start;
      #31 sdaM = 1'b1;
      #31 scl = 1'b1;
      #32 sdaM = 1'b0;
      #31 scl = 1'b0;
   endtask
   task automatic stop;
      #31 sdaM = 1'b0;
      #31 scl = 1'b1;
      #32 sdaM = 1'b1;
      #31;
   endtask
   task automatic wrByte(input logic [7:0] d, output logic ack);
      logic s;
      scl = 1'b0;
      for (int i = 7; i >= 0; i--) bitx(d[i], s);
      bitx(1'b1, s);
      ack = ~s;
   endtask
   task automatic rdByte(input logic ackIt, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
      bitx(~ackIt, s);
   endtask
endmodule // tw_master_model
